// ### src/tgw_map.svh
`ifndef TGW_MAP_SVH
`define TGW_MAP_SVH

// clock rate and timebase
`define TGW_CLK_KHZ        100000
`define TGW_TICK_MS        100
`define TGW_TICK_CYCLES    (`TGW_TICK_MS * `TGW_CLK_KHZ)
`define TGW_TICKS_PER_S    4'hA
`define TGW_FLASH_MS       600
`define TGW_FLASH_TICKS    (`TGW_FLASH_MS / `TGW_TICK_MS)
`define TGW_BEEP_TICKS     4'h1

// polarity selector encoding
`define TGW_POL_OPEN       2'h0
`define TGW_POL_GND        2'h1
`define TGW_POL_UNUSED     2'h2
`define TGW_POL_12V        2'h3

// gear interlock modes
`define TGW_GEAR_IGNORE    2'h0
`define TGW_GEAR_NOT_REV   2'h1
`define TGW_GEAR_ONLY_REV  2'h2
`define TGW_GEAR_OR_REV    2'h3

// configuration ranges and defaults
`define TGW_CONT_MAX_S     6'h3C
`define TGW_CONT_DEF_S     6'h0A
`define TGW_INTV_MIN_S     6'h0A
`define TGW_INTV_MAX_S     6'h3C
`define TGW_INTV_DEF_S     6'h14
`define TGW_POL_DEF        2'h3
`define TGW_GEAR_DEF       2'h3
`define TGW_BRAKE_DEF      1'h0

// pin level bits: [1] pin at 12 V, [0] pin grounded
`define TGW_LVL_12V_BIT    1
`define TGW_LVL_GND_BIT    0

`endif

// ### src/tgw_pkg.sv
package tgw_pkg;

  typedef enum logic [1:0] {
    TGW_IDLE,
    TGW_CONT,
    TGW_PERIODIC
  } tgw_state_t;

  // state of the input qualifier
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] lvl;
    logic       active;
  } tgw_qual_t;

  // state of the warning core
  typedef struct packed {
    tgw_state_t  st;
    logic [23:0] tick_cnt;
    logic [3:0]  sub_cnt;
    logic [3:0]  flash_cnt;
    logic [5:0]  sec_cnt;
    logic [3:0]  beep_cnt;
    logic        flash_ph;
    logic        gate_lamp;
    logic        rear_lamp;
    logic        alarm;
  } tgw_core_t;

endpackage : tgw_pkg

// ### src/tgw_input_qual.sv
`timescale 1ns/100ps
`include "tgw_map.svh"

// brings one pin level into the clock domain and judges it active
module tgw_input_qual (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [1:0] pin_level,
  input  wire logic [1:0] polarity_sel,
  output logic            active
);

  tgw_pkg::tgw_qual_t s_q;
  tgw_pkg::tgw_qual_t s_d;

  // second stage alone feeds the decode; first stage is read only by the second
  always_comb begin
    s_d      = s_q;
    s_d.meta = pin_level;
    s_d.lvl  = s_q.meta;
    case (polarity_sel)
      `TGW_POL_OPEN: s_d.active = ~s_q.lvl[`TGW_LVL_12V_BIT] &
                                  ~s_q.lvl[`TGW_LVL_GND_BIT];
      `TGW_POL_GND:  s_d.active = s_q.lvl[`TGW_LVL_GND_BIT];
      `TGW_POL_12V:  s_d.active = s_q.lvl[`TGW_LVL_12V_BIT];
      default:       s_d.active = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign active = s_q.active;

endmodule : tgw_input_qual

// ### src/tgw_tailgate_warn.sv
// Overview of operation
// - gate sense judged active by 2-bit polarity: open, ground, unused, 12 V
// - with brake-released-only set, gate alert only while brake released
// - gear mode 0 ignores gear, 1 not in reverse, 2 only in reverse
// - gear mode 3 alerts on gate sense or reverse, whichever occurs
// - gate open and brake released: continuous alarm for 0..60 s setting
// - continuous time 0 means alarm stays on while the gate condition holds with brake released
// - after continuous time, single beeps spaced by 10..60 s interval
// - driver-call input judged active by its own 2-bit polarity selector
// - park brake set with gate condition: gate lamp lit steadily
// - brake released with gate condition: lamp flashes, alarm per timing
// - gate lamp flash toggles every 0.6 seconds
// - active driver call lights the rear-alert lamp and sounds the alarm
// - driver call works only with the key in ignition position
`timescale 1ns/100ps
`include "tgw_map.svh"

module tgw_tailgate_warn #(
  parameter int unsigned TICK_CYCLES = `TGW_TICK_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [1:0] gate_sense_level,
  input  wire logic [1:0] driver_call_level,
  input  wire logic       park_brake_set,
  input  wire logic       in_reverse,
  input  wire logic       ignition_on,
  input  wire logic [1:0] gate_input_polarity_sel,
  input  wire logic [1:0] driver_call_polarity_sel,
  input  wire logic       brake_released_only,
  input  wire logic [1:0] gear_interlock_mode,
  input  wire logic [5:0] continuous_beep_time_s,
  input  wire logic [5:0] beep_interval_s,
  output logic            gate_open_lamp,
  output logic            rear_alert_lamp,
  output logic            alarm_on
);

  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
  localparam logic [3:0]  FLASH_LAST = 4'(`TGW_FLASH_TICKS - 1);
  localparam logic [3:0]  SUB_LAST = `TGW_TICKS_PER_S - 4'h1;

  logic gate_act;
  logic call_act;
  logic brake_s;
  logic rev_s;
  logic ign_s;

  tgw_pkg::tgw_core_t s_q;
  tgw_pkg::tgw_core_t s_d;

  // every pin goes through the same two-stage qualifier
  tgw_input_qual u_gate (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .pin_level    (gate_sense_level),
    .polarity_sel (gate_input_polarity_sel),
    .active       (gate_act)
  );

  tgw_input_qual u_call (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .pin_level    (driver_call_level),
    .polarity_sel (driver_call_polarity_sel),
    .active       (call_act)
  );

  // vehicle status lines are plain active-high levels
  tgw_input_qual u_brake (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .pin_level    ({park_brake_set, 1'b0}),
    .polarity_sel (`TGW_POL_12V),
    .active       (brake_s)
  );

  tgw_input_qual u_rev (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .pin_level    ({in_reverse, 1'b0}),
    .polarity_sel (`TGW_POL_12V),
    .active       (rev_s)
  );

  tgw_input_qual u_ign (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .pin_level    ({ign_on_level(ignition_on), 1'b0}),
    .polarity_sel (`TGW_POL_12V),
    .active       (ign_s)
  );

  function automatic logic ign_on_level(input logic v);
    ign_on_level = v;
  endfunction : ign_on_level

  logic       gear_ok;
  logic       gate_cond;
  logic [5:0] cont_lim;
  logic [5:0] intv_lim;
  logic       tick;

  // gear interlock and brake qualification of the gate alert
  always_comb begin
    case (gear_interlock_mode)
      `TGW_GEAR_IGNORE:   gear_ok = gate_act;
      `TGW_GEAR_NOT_REV:  gear_ok = gate_act & ~rev_s;
      `TGW_GEAR_ONLY_REV: gear_ok = gate_act & rev_s;
      default:            gear_ok = gate_act | rev_s;
    endcase
    gate_cond = gear_ok & ~(brake_released_only & brake_s);
  end

  // out-of-range settings clamp rather than stall the timers
  always_comb begin
    cont_lim = continuous_beep_time_s;
    if (continuous_beep_time_s > `TGW_CONT_MAX_S) begin
      cont_lim = `TGW_CONT_MAX_S;
    end
    intv_lim = beep_interval_s;
    if (beep_interval_s < `TGW_INTV_MIN_S) begin
      intv_lim = `TGW_INTV_MIN_S;
    end else if (beep_interval_s > `TGW_INTV_MAX_S) begin
      intv_lim = `TGW_INTV_MAX_S;
    end
  end

  assign tick = (s_q.tick_cnt == TICK_LAST);

  // warning sequencer, all state in one struct
  always_comb begin
    logic sec;
    logic warn;
    logic call_on;
    sec     = 1'b0;
    warn    = 1'b0;
    call_on = 1'b0;
    s_d     = s_q;

    // free-running timebase of 0.1 s ticks
    s_d.tick_cnt = tick ? 24'h000000 : s_q.tick_cnt + 24'h000001;
    if (tick) begin
      s_d.sub_cnt = (s_q.sub_cnt == SUB_LAST) ? 4'h0
                                               : s_q.sub_cnt + 4'h1;
      sec = (s_q.sub_cnt == SUB_LAST);
    end

    warn = gate_cond & ~brake_s;
    case (s_q.st)
      tgw_pkg::TGW_IDLE: begin
        if (warn) begin
          s_d.st        = tgw_pkg::TGW_CONT;
          s_d.sec_cnt   = 6'h00;
          s_d.sub_cnt   = 4'h0;
          s_d.flash_cnt = 4'h0;
          s_d.flash_ph  = 1'b1; // flash starts in the lit phase
        end
      end
      tgw_pkg::TGW_CONT: begin
        if (!warn) begin
          s_d.st = tgw_pkg::TGW_IDLE;
        end else if (sec && cont_lim != 6'h00) begin
          s_d.sec_cnt = s_q.sec_cnt + 6'h01;
          if (s_q.sec_cnt + 6'h01 >= cont_lim) begin
            s_d.st       = tgw_pkg::TGW_PERIODIC;
            s_d.sec_cnt  = 6'h00;
          end
        end
      end
      tgw_pkg::TGW_PERIODIC: begin
        if (!warn) begin
          s_d.st = tgw_pkg::TGW_IDLE;
        end else if (cont_lim == 6'h00) begin
          // endless setting taken mid-warning, not only at entry
          s_d.st = tgw_pkg::TGW_CONT;
        end else if (sec) begin
          if (s_q.sec_cnt + 6'h01 >= intv_lim) begin
            s_d.sec_cnt  = 6'h00;
            s_d.beep_cnt = `TGW_BEEP_TICKS;
          end else begin
            s_d.sec_cnt = s_q.sec_cnt + 6'h01;
          end
        end
      end
      default: begin
        s_d.st = tgw_pkg::TGW_IDLE;
      end
    endcase

    // single beep runs down on the 0.1 s tick
    if (s_d.st != tgw_pkg::TGW_PERIODIC) begin
      s_d.beep_cnt = 4'h0;
    end else if (tick && s_q.beep_cnt != 4'h0 && !sec) begin
      s_d.beep_cnt = s_q.beep_cnt - 4'h1;
    end

    // flash phase toggles every 0.6 s while the brake is released
    if (s_q.st != tgw_pkg::TGW_IDLE && tick) begin
      if (s_q.flash_cnt == FLASH_LAST) begin
        s_d.flash_cnt = 4'h0;
        s_d.flash_ph  = ~s_q.flash_ph;
      end else begin
        s_d.flash_cnt = s_q.flash_cnt + 4'h1;
      end
    end

    call_on = call_act & ign_s;

    // lamp: steady with brake set, flashing once released
    if (gate_cond && brake_s) begin
      s_d.gate_lamp = 1'b1;
    end else if (s_d.st != tgw_pkg::TGW_IDLE) begin
      s_d.gate_lamp = s_d.flash_ph;
    end else begin
      s_d.gate_lamp = 1'b0;
    end

    s_d.rear_lamp = call_on;
    s_d.alarm     = call_on |
                    (s_d.st == tgw_pkg::TGW_CONT) |
                    (s_d.beep_cnt != 4'h0);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign gate_open_lamp  = s_q.gate_lamp;
  assign rear_alert_lamp = s_q.rear_lamp;
  assign alarm_on        = s_q.alarm;

endmodule : tgw_tailgate_warn

// ### src/unused_placeholder_none.sv
`timescale 1ns/100ps

// ### dv/tgw_vehicle_model.sv
`timescale 1ns/100ps

// builder switch wiring: turns switch state into the two pin level bits
module tgw_vehicle_model (
  input  wire logic       gate_open,
  input  wire logic       call_on,
  input  wire logic [1:0] gate_wiring,
  input  wire logic [1:0] call_wiring,
  output logic [1:0]      gate_sense_level,
  output logic [1:0]      driver_call_level
);
  // code 2 has no switch fitted, so the pin just floats open
  function automatic logic [1:0] pin_of(input logic [1:0] w, input logic a);
    case (w)
      2'h0: return a ? 2'h0 : 2'h2;
      2'h1: return a ? 2'h1 : 2'h0;
      2'h3: return a ? 2'h2 : 2'h0;
      default: return 2'h0;
    endcase
  endfunction : pin_of
  // gate sense and driver call pins both go through the same switch wiring map
  assign gate_sense_level  = pin_of(gate_wiring, gate_open);
  assign driver_call_level = pin_of(call_wiring, call_on);
endmodule : tgw_vehicle_model

// ### dv/tgw_properties.sv
`timescale 1ns/100ps

module tgw_properties #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic [1:0] gate_sense_level,
  input wire logic [1:0] driver_call_level,
  input wire logic       park_brake_set,
  input wire logic       in_reverse,
  input wire logic       ignition_on,
  input wire logic [1:0] gate_input_polarity_sel,
  input wire logic [1:0] driver_call_polarity_sel,
  input wire logic       brake_released_only,
  input wire logic [1:0] gear_interlock_mode,
  input wire logic [5:0] continuous_beep_time_s,
  input wire logic       gate_open_lamp,
  input wire logic       rear_alert_lamp,
  input wire logic       alarm_on
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [31:0] gap_q;
  logic        rel_q;
  // armed only after a flash-off, so entry and cause changes are skipped
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gap_q <= 32'h0;
      rel_q <= 1'b0;
    end else begin
      gap_q <= $changed(gate_open_lamp) ? 32'h0 : gap_q + 32'h1;
      rel_q <= (park_brake_set || !in_reverse) ? 1'b0 :
               ($fell(gate_open_lamp) ? 1'b1 : rel_q);
    end
  end
  sequence s_flash_on;
    $rose(gate_open_lamp) && rel_q && gear_interlock_mode == 2'h3;
  endsequence
  AST_GATE_POL: assert property (
    (park_brake_set && !brake_released_only &&
     gate_input_polarity_sel == 2'h3 && gate_sense_level == 2'h2 &&
     gear_interlock_mode == 2'h0)[*7] |-> gate_open_lamp)
    else $error("gate lamp not steady");
  AST_BRAKE_ONLY: assert property (
    (brake_released_only && park_brake_set &&
     gear_interlock_mode == 2'h0)[*7] |-> !gate_open_lamp)
    else $error("gate lamp lit with brake set");
  AST_NOT_REV: assert property (
    (gear_interlock_mode == 2'h1 && in_reverse)[*7] |-> !gate_open_lamp)
    else $error("gate lamp lit in reverse");
  AST_OR_REV: assert property (
    (gear_interlock_mode == 2'h3 && in_reverse &&
     park_brake_set && !brake_released_only)[*7] |-> gate_open_lamp)
    else $error("reverse did not light gate lamp");
  AST_ENDLESS: assert property (
    (continuous_beep_time_s == 6'h0 && in_reverse &&
     gear_interlock_mode == 2'h3 && !park_brake_set)[*7] |-> alarm_on)
    else $error("endless alarm dropped");
  AST_CALL: assert property (
    (ignition_on && driver_call_level == 2'h2 &&
     driver_call_polarity_sel == 2'h3)[*7] |-> rear_alert_lamp && alarm_on)
    else $error("driver call not signalled");
  AST_NO_IGN: assert property (
    (!ignition_on)[*7] |-> !rear_alert_lamp)
    else $error("rear lamp lit without ignition");
  AST_FLASH: assert property (s_flash_on |->
    gap_q inside {[6*TICK_CYCLES-2:6*TICK_CYCLES]})
    else $error("flash period wrong");
endmodule : tgw_properties

bind tgw_tailgate_warn tgw_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .sys_clk(sys_clk), .rstn(rstn), .gate_sense_level(gate_sense_level),
  .driver_call_level(driver_call_level), .park_brake_set(park_brake_set),
  .in_reverse(in_reverse), .ignition_on(ignition_on),
  .gate_input_polarity_sel(gate_input_polarity_sel),
  .driver_call_polarity_sel(driver_call_polarity_sel),
  .brake_released_only(brake_released_only),
  .gear_interlock_mode(gear_interlock_mode),
  .continuous_beep_time_s(continuous_beep_time_s),
  .gate_open_lamp(gate_open_lamp), .rear_alert_lamp(rear_alert_lamp),
  .alarm_on(alarm_on));

// ### dv/tgw_tailgate_warn_test.sv
`timescale 1ns/100ps

module tgw_tailgate_warn_test;
  localparam int unsigned TICK = 10;
  logic       sys_clk, rstn, gate_open, call_on, brake, rev, ign, bro;
  logic       lamp, rear, alarm;
  logic [1:0] gpol, cpol, mode, glvl, clvl;
  logic [5:0] cont, intv;
  int         err_total, check_count, cyc, n, m, r, g, p;

  tgw_vehicle_model u_veh (.gate_open(gate_open), .call_on(call_on),
    .gate_wiring(gpol), .call_wiring(cpol), .gate_sense_level(glvl),
    .driver_call_level(clvl));
  tgw_tailgate_warn #(.TICK_CYCLES(TICK)) DUT (.sys_clk(sys_clk),
    .rstn(rstn), .gate_sense_level(glvl), .driver_call_level(clvl),
    .park_brake_set(brake), .in_reverse(rev), .ignition_on(ign),
    .gate_input_polarity_sel(gpol), .driver_call_polarity_sel(cpol),
    .brake_released_only(bro), .gear_interlock_mode(mode),
    .continuous_beep_time_s(cont), .beep_interval_s(intv),
    .gate_open_lamp(lamp), .rear_alert_lamp(rear), .alarm_on(alarm));

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  task step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : step
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task summarize;
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // length of the current alarm level, bounded so a stuck alarm cannot hang
  task run_len(input logic v, output int k);
    k = 0;
    while (alarm === v && k < 3000) begin
      step(1);
      k++;
    end
  endtask : run_len

  // hang guard, well above the few thousand cycles the tests need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 12000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    {rstn, gate_open, call_on, rev, bro, mode} = 7'h00;
    {brake, ign, gpol, cpol} = 6'h3F;
    cont = 6'h0A;
    intv = 6'h14;
    step(4);
    rstn = 1'b1;
    step(2);
    // every polarity code on both switches, brake set
    for (p = 0; p < 4; p++) begin
      gpol = p[1:0];
      cpol = p[1:0];
      {gate_open, call_on} = 2'h3;
      step(10);
      check({lamp, rear, alarm}, {3{p != 2}});
      {gate_open, call_on} = 2'h0;
      step(10);
      check({lamp, alarm}, 2'h0);
    end
    {gpol, cpol, call_on, ign} = 6'h3E;
    step(10);
    check({rear, alarm}, 2'h0);
    {call_on, ign, bro, gate_open} = 4'h7;
    step(10);
    check(lamp, 1'b0);
    brake = 1'b0;
    step(10);
    check({lamp, alarm}, 2'h3);
    {brake, bro} = 2'h2;
    // gear interlock table with the brake set
    for (m = 0; m < 4; m++) begin
      for (r = 0; r < 2; r++) begin
        for (g = 0; g < 2; g++) begin
          {mode, rev, gate_open} = {m[1:0], r[0], g[0]};
          step(10);
          check(lamp, m == 0 ? g : m == 1 ? g && !r :
                m == 2 ? g && r : g || r);
        end
      end
    end
    {mode, rev, gate_open, cont, intv} = {4'h1, 6'h01, 6'h0A};
    step(10);
    brake = 1'b0;
    run_len(1'b0, n);
    run_len(1'b1, n);
    check(n >= 90 && n <= 110, 1'b1);
    run_len(1'b0, n);
    run_len(1'b1, n);
    check(n >= TICK - 1 && n <= TICK + 1, 1'b1);
    run_len(1'b0, n);
    check(n >= 985 && n <= 995, 1'b1);
    {brake, gate_open} = 2'h2;
    step(10);
    {cont, mode, rev} = {6'h00, 3'h7};
    step(10);
    brake = 1'b0;
    for (n = 0; n < 20; n++) begin
      step(10);
      check(alarm, 1'b1);
    end
    // lit cycles over one full flash period: a stuck lamp gives 0 or 12 ticks
    n = 0;
    for (m = 0; m < 12 * TICK; m++) begin
      step(1);
      n += (lamp === 1'b1);
    end
    check(n, 6 * TICK);
    summarize();
  end
endmodule : tgw_tailgate_warn_test
